// ==== core/fdl_core.sv ====
/*
  per-channel receive gap-clock selection and hdlc data link with
  transmit and receive fifos, reached over classic wishbone.
  assumes line clocks and line strobes arrive asynchronously and are
  far slower than clk_i; overhead classes come from the framer, the mode from the OFF_MODE register.
*/
`timescale 1ns/100ps
`default_nettype none
module fdl_core import fdl_pkg::*; #(
  parameter int DEPTH = 128
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_extract_clock_i,
  input wire logic rx_line_data_i,
  input wire logic rx_ovh_pos_i,
  input wire logic rx_stuff_pos_i,
  input wire logic rx_justif_pos_i,
  input wire logic rx_link_slot_i,
  input wire logic rx_nr_slot_i,
  input wire logic tx_line_clock_i,
  input wire logic tx_link_slot_i,
  output logic rx_gapped_clock_o,
  output logic rx_serial_out_o,
  output logic tx_link_bit_o,
  output logic irq_out_n_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [SY_W-1:0] s1;
    logic [SY_W-1:0] s2;
    logic [SY_W-1:0] s3;
    logic [2:0] ovh;
    logic [3:0] txc;
    logic [6:0] txthr;
    logic [7:0] txmsg;
    logic [5:0] rxc;
    logic [6:0] rxthr;
    logic [1:0] mode;
    logic [6:0] st;
    logic ack;
    logic [7:0] rdat;
    logic tick;
    logic gclk;
    logic rdo;
    logic [AW:0] twp;
    logic [AW:0] trp;
    fdl_tx_st_t tst;
    logic [15:0] tsh;
    logic [4:0] tcnt;
    logic [2:0] tones;
    logic [15:0] tcrc;
    logic tlast;
    logic tbit;
    logic [AW:0] rwp;
    logic [AW:0] rrp;
    logic rin;
    logic rnb;
    logic [2:0] rones;
    logic [7:0] rsh;
    logic [2:0] rcnt;
    logic [15:0] rcrc;
    logic [15:0] rcrcb;
    logic irqn;
  } fdl_state_t;

  fdl_state_t state_q, state_d;
  logic [8:0] tx_mem [DEPTH];
  logic [7:0] rx_mem [DEPTH];
  logic tx_we, rx_we, acc, wr, rd, rrise, trise, sl, b;
  logic [7:0] rx_wdat;
  logic [8:0] tx_head;
  logic [AW:0] tocc, rocc;
  logic [6:0] setv, clrv, mask;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    setv = 7'h00;
    clrv = 7'h00;
    tx_we = 1'b0;
    rx_we = 1'b0;
    b = 1'b0;
    rx_wdat = {state_d.s2[SY_RDT], state_q.rsh[7:1]};
    tx_head = tx_mem[state_q.trp[AW-1:0]];
    tocc = state_q.twp - state_q.trp;
    rocc = state_q.rwp - state_q.rrp;
    // pin synchronisers; edges seen between second and third stage
    state_d.s1 = {tx_link_slot_i, tx_line_clock_i, rx_nr_slot_i, rx_link_slot_i,
                  rx_justif_pos_i, rx_stuff_pos_i, rx_ovh_pos_i, rx_line_data_i,
                  rx_extract_clock_i};
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
    rrise = state_q.s2[SY_RCK] & ~state_q.s3[SY_RCK];
    trise = state_q.s2[SY_TCK] & ~state_q.s3[SY_TCK];
    // wishbone: answer one cycle after the strobe
    acc = wb_cyc_i & wb_stb_i & ~state_q.ack;
    wr = acc & wb_we_i & wb_sel_i[0];
    rd = acc & ~wb_we_i;
    state_d.ack = acc;
    state_d.rdat = 8'h00;
    if (wr) begin
      case (wb_adr_i)
        OFF_OVH: state_d.ovh = wb_dat_i[2:0];
        OFF_TXC: state_d.txc = wb_dat_i[3:0];
        OFF_TXT: state_d.txthr = wb_dat_i[6:0];
        OFF_TXM, OFF_TXL: begin
          state_d.txmsg = wb_dat_i[7:0];
          if (tocc != FULL) begin
            tx_we = 1'b1;
            state_d.twp = state_q.twp + 1'b1;
          end
        end
        OFF_RXC: state_d.rxc = wb_dat_i[5:0];
        OFF_RXT: state_d.rxthr = wb_dat_i[6:0];
        OFF_MODE: state_d.mode = wb_dat_i[1:0];
        default: ;
      endcase
    end
    if (rd) begin
      case (wb_adr_i)
        OFF_OVH: state_d.rdat = {5'h00, state_q.ovh};
        OFF_TXC: state_d.rdat = {4'h0, state_q.txc};
        OFF_TXT: state_d.rdat = {1'b0, state_q.txthr};
        OFF_TXM, OFF_TXL: begin
          state_d.txmsg = tx_head[7:0];
          state_d.rdat = tx_head[7:0];
        end
        OFF_RXC: state_d.rdat = {2'h0, state_q.rxc};
        OFF_RXT: state_d.rdat = {1'b0, state_q.rxthr};
        OFF_ST: begin
          state_d.rdat = {1'b0, state_q.st};
          clrv = state_q.st;
        end
        OFF_RXB: begin
          state_d.rdat = rx_mem[state_q.rrp[AW-1:0]];
          if (rocc != '0) state_d.rrp = state_q.rrp + 1'b1;
        end
        OFF_MODE: state_d.rdat = {6'h00, state_q.mode};
        default: ;
      endcase
    end
    // gap clock: decide per line bit at its rising edge
    if (rrise) begin
      if (state_q.ovh[OV_ALL]) state_d.tick = 1'b1;
      else if (!state_q.s2[SY_OVH]) state_d.tick = 1'b1;
      else if (state_q.mode == MODE_M13 || state_q.mode == MODE_G751)
        state_d.tick = (state_q.s2[SY_STF] & state_q.ovh[OV_STF]) |
                       (state_q.s2[SY_CJ] & state_q.ovh[OV_CJ]);
      else state_d.tick = 1'b0;
      if (state_d.tick) state_d.rdo = state_q.s2[SY_RDT];
    end
    state_d.gclk = state_q.s2[SY_RCK] & state_d.tick;
    // transmit hdlc serialiser, one bit per link slot
    if (trise && state_q.s2[SY_TSL]) begin
      // five ones also need a stuffed zero when a flag follows the last byte
      if (state_q.tones == 3'd5 && (state_q.tst != TX_FLAG || state_q.tcnt == CNT_BYTE)) begin
        state_d.tbit = 1'b0;
        state_d.tones = 3'd0;
      end else begin
        b = state_q.tsh[0];
        state_d.tbit = b;
        state_d.tones = b ? state_q.tones + 3'd1 : 3'd0;
        if (state_q.tst == TX_DATA) state_d.tcrc = fdl_crc(state_q.tcrc, b);
        state_d.tsh = state_q.tsh >> 1;
        state_d.tcnt = state_q.tcnt - 5'd1;
        if (state_q.tcnt == 5'd1) begin
          state_d.tst = TX_FLAG;
          state_d.tsh = {8'h00, HDLC_FLAG};
          state_d.tcnt = CNT_BYTE;
          case (state_q.tst)
            TX_FLAG: ;
            TX_DATA: begin
              if (state_q.tlast && state_q.txc[TC_FCS]) begin
                state_d.tst = TX_FCS;
                state_d.tsh = ~state_d.tcrc;
                state_d.tcnt = CNT_FCS;
              end else if (state_q.tlast) setv[ST_TXDONE] = 1'b1;
              else if (tocc == '0) setv[ST_TXUR] = 1'b1;
            end
            TX_FCS: setv[ST_TXDONE] = 1'b1;
            default: ;
          endcase
          // next byte follows a flag, or the previous byte of a message
          if (tocc != '0 && (state_q.tst == TX_FLAG ||
              (state_q.tst == TX_DATA && !state_q.tlast))) begin
            state_d.tst = TX_DATA;
            state_d.tsh = {8'h00, tx_head[7:0]};
            state_d.tlast = tx_head[8];
            state_d.tcnt = CNT_BYTE;
            state_d.trp = state_q.trp + 1'b1;
            if (state_q.tst == TX_FLAG) state_d.tcrc = CRC_INIT;
          end
        end
      end
    end
    // receive hdlc: nr or gc byte in g832, else the single channel
    sl = (state_q.mode == MODE_G832 && state_q.rxc[RC_NR]) ?
         state_q.s2[SY_RNR] : state_q.s2[SY_RSL];
    if (rrise && sl && state_q.rxc[RC_EN]) begin
      b = state_q.s2[SY_RDT];
      if (b && state_q.rones == 3'd6) begin
        state_d.rin = 1'b0; // abort: hunt for the next flag
        state_d.rones = 3'd7;
      end else if (!b && state_q.rones == 3'd6) begin
        if (state_q.rin && state_q.rnb && state_q.rcnt == 3'd7) begin
          setv[ST_RXMSG] = 1'b1;
          if (state_q.rxc[RC_FCS] && state_q.rcrcb != CRC_GOOD)
            setv[ST_RXBAD] = 1'b1;
        end
        state_d.rin = 1'b1;
        state_d.rnb = 1'b0;
        state_d.rcnt = 3'd0;
        state_d.rcrc = CRC_INIT;
        state_d.rcrcb = CRC_INIT;
        state_d.rones = 3'd0;
      end else if (!b && state_q.rones == 3'd5) begin
        state_d.rones = 3'd0; // stuffed zero dropped
      end else begin
        state_d.rones = b ? ((state_q.rones == 3'd7) ? 3'd7 : state_q.rones + 3'd1)
                          : 3'd0;
        if (state_q.rin) begin
          state_d.rsh = {b, state_q.rsh[7:1]};
          state_d.rcrc = fdl_crc(state_q.rcrc, b);
          state_d.rcnt = state_q.rcnt + 3'd1;
          if (state_q.rcnt == 3'd7) begin
            state_d.rnb = 1'b1;
            state_d.rcrcb = state_d.rcrc;
            if (rocc == FULL) setv[ST_RXOVR] = 1'b1;
            else begin
              rx_we = 1'b1;
              state_d.rwp = state_q.rwp + 1'b1;
            end
          end
        end
      end
    end
    // level events, sticky status; a new event wins over the read clear
    if (state_d.twp - state_d.trp <= (AW+1)'(state_q.txthr)) setv[ST_TXNE] = 1'b1;
    if (state_q.rxc[RC_EN] && rocc >= (AW+1)'(state_q.rxthr)) setv[ST_RXNF] = 1'b1;
    state_d.st = (state_q.st & ~clrv) | setv;
    mask[ST_TXDONE] = state_q.txc[TC_MSGIE];
    mask[ST_TXUR] = state_q.txc[TC_URIE];
    mask[ST_TXNE] = state_q.txc[TC_NEIE];
    mask[ST_RXOVR] = state_q.rxc[RC_OVRIE] & state_q.rxc[RC_EN];
    mask[ST_RXMSG] = state_q.rxc[RC_MSGIE] & state_q.rxc[RC_EN];
    mask[ST_RXNF] = state_q.rxc[RC_NFIE] & state_q.rxc[RC_EN];
    mask[ST_RXBAD] = mask[ST_RXMSG] & state_q.rxc[RC_FCS];
    state_d.irqn = ~|(state_d.st & mask);
  end

  // ------------------------------------------------------------------
  // registers and fifo storage
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= '0;
      state_q.rxthr <= RXT_RST;
      state_q.irqn <= 1'b1;
      state_q.tst <= TX_FLAG;
      state_q.tsh <= {8'h00, HDLC_FLAG};
      state_q.tcnt <= CNT_BYTE;
      state_q.tcrc <= CRC_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  // fifo arrays; a write to the higher address tags the byte as last
  always_ff @(posedge clk_i) begin
    if (tx_we) tx_mem[state_q.twp[AW-1:0]] <= {wb_adr_i == OFF_TXL, wb_dat_i[7:0]};
    if (rx_we) rx_mem[state_q.rwp[AW-1:0]] <= rx_wdat;
  end

  assign wb_dat_o = {24'h000000, state_q.rdat};
  assign wb_ack_o = state_q.ack;
  assign rx_gapped_clock_o = state_q.gclk;
  assign rx_serial_out_o = state_q.rdo;
  assign tx_link_bit_o = state_q.tbit;
  assign irq_out_n_o = state_q.irqn;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_all_ovh;
    @(posedge clk_i) disable iff (rst_i)
    (rrise && state_q.ovh[OV_ALL]) |=> state_q.tick;
  endproperty
  a_all_ovh: assert property (p_all_ovh) else $error("all overhead bit gapped");

  property p_stuff;
    @(posedge clk_i) disable iff (rst_i)
    (rrise && !state_q.ovh[OV_ALL] && state_q.s2[SY_OVH] && state_q.mode == MODE_M13 &&
     state_q.s2[SY_STF] && !state_q.s2[SY_CJ]) |=> (state_q.tick == $past(state_q.ovh[OV_STF]));
  endproperty
  a_stuff: assert property (p_stuff) else $error("stuff bit tick wrong");

  property p_justif;
    @(posedge clk_i) disable iff (rst_i)
    (rrise && !state_q.ovh[OV_ALL] && state_q.s2[SY_OVH] && state_q.mode == MODE_G751 &&
     state_q.s2[SY_CJ] && !state_q.s2[SY_STF]) |=> (state_q.tick == $past(state_q.ovh[OV_CJ]));
  endproperty
  a_justif: assert property (p_justif) else $error("justification tick wrong");

  property p_cbit_ign;
    @(posedge clk_i) disable iff (rst_i)
    (rrise && !state_q.ovh[OV_ALL] && state_q.s2[SY_OVH] &&
     (state_q.mode == MODE_CBIT || state_q.mode == MODE_G832)) |=> !state_q.tick;
  endproperty
  a_cbit_ign: assert property (p_cbit_ign) else $error("overhead ticked in cbit/g832");

  property p_payload;
    @(posedge clk_i) disable iff (rst_i)
    (rrise && !state_q.s2[SY_OVH]) |=> state_q.tick ##1 (state_q.gclk == state_q.s3[SY_RCK]);
  endproperty
  a_payload: assert property (p_payload) else $error("payload bit gapped");

  property p_txdone_irq;
    @(posedge clk_i) disable iff (rst_i)
    (setv[ST_TXDONE] && state_q.txc[TC_MSGIE]) |=> !irq_out_n_o;
  endproperty
  a_txdone_irq: assert property (p_txdone_irq) else $error("no message-done irq");

  property p_eom;
    @(posedge clk_i) disable iff (rst_i)
    tx_we |=> (tx_mem[$past(state_q.twp[AW-1:0])][8] == $past(wb_adr_i == OFF_TXL));
  endproperty
  a_eom: assert property (p_eom) else $error("end-of-message tag wrong");

  property p_rx_quiet;
    @(posedge clk_i) disable iff (rst_i)
    (!state_q.rxc[RC_EN] && state_q.st[6:3] == 4'h0) |=> (state_q.st[6:3] == 4'h0);
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("rx event while disabled");

  property p_nf_rst;
    @(posedge clk_i) rst_i |=> (state_q.rxthr == RXT_RST && irq_out_n_o);
  endproperty
  a_nf_rst: assert property (p_nf_rst) else $error("bad reset state");
endmodule : fdl_core
`default_nettype wire

// ==== shared/fdl_pkg.sv ====
/*
  constants, types and helpers of the per-channel data-link and
  receive gapped-clock logic.
  assumes a 32-bit classic wishbone slave with byte addresses.
*/
`default_nettype none
package fdl_pkg;
  // ------------------------------------------------------------------
  // register map (byte offsets)
  // ------------------------------------------------------------------
  localparam logic [5:0] OFF_OVH = 6'h00;
  localparam logic [5:0] OFF_TXC = 6'h04;
  localparam logic [5:0] OFF_TXT = 6'h08;
  localparam logic [5:0] OFF_TXM = 6'h0C;
  localparam logic [5:0] OFF_TXL = 6'h10;
  localparam logic [5:0] OFF_RXC = 6'h14;
  localparam logic [5:0] OFF_RXT = 6'h18;
  localparam logic [5:0] OFF_ST = 6'h1C;
  localparam logic [5:0] OFF_RXB = 6'h20;
  localparam logic [5:0] OFF_MODE = 6'h24;
  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int OV_ALL = 0, OV_CJ = 1, OV_STF = 2;
  localparam int TC_FCS = 0, TC_NEIE = 1, TC_URIE = 2, TC_MSGIE = 3;
  localparam int RC_EN = 0, RC_FCS = 1, RC_NFIE = 2, RC_MSGIE = 3;
  localparam int RC_OVRIE = 4, RC_NR = 5;
  localparam int ST_TXDONE = 0, ST_TXUR = 1, ST_TXNE = 2, ST_RXOVR = 3;
  localparam int ST_RXMSG = 4, ST_RXNF = 5, ST_RXBAD = 6;
  // synchroniser lanes
  localparam int SY_RCK = 0, SY_RDT = 1, SY_OVH = 2, SY_STF = 3;
  localparam int SY_CJ = 4, SY_RSL = 5, SY_RNR = 6, SY_TCK = 7;
  localparam int SY_TSL = 8, SY_W = 9;
  // ------------------------------------------------------------------
  // reset values, modes, hdlc constants
  // ------------------------------------------------------------------
  localparam logic [6:0] RXT_RST = 7'h7F;
  localparam logic [1:0] MODE_M13 = 2'h0;
  localparam logic [1:0] MODE_CBIT = 2'h1;
  localparam logic [1:0] MODE_G751 = 2'h2;
  localparam logic [1:0] MODE_G832 = 2'h3;
  localparam logic [7:0] HDLC_FLAG = 8'h7E;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hF0B8;
  localparam logic [4:0] CNT_BYTE = 5'h08;
  localparam logic [4:0] CNT_FCS = 5'h10;

  typedef enum logic [1:0] {
    TX_FLAG = 2'b00,
    TX_DATA = 2'b01,
    TX_FCS = 2'b10
  } fdl_tx_st_t;

  // one bit of the reflected 16-bit hdlc check sequence
  function automatic logic [15:0] fdl_crc(input logic [15:0] c, input logic b);
    fdl_crc = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
  endfunction : fdl_crc
endpackage : fdl_pkg
`default_nettype wire

// ==== sim/fdl_far_model.sv ====
/*
  far-side model: framer line clocks, overhead class strobes and a
  decoder of the transmit link bit stream.
  assumes the core samples line strobes at each line-clock rise.
*/
`timescale 1ns/100ps
`default_nettype none
module fdl_far_model (
  output logic rx_clk_o,
  output logic rx_dat_o,
  output logic ovh_o,
  output logic stf_o,
  output logic cj_o,
  output logic slot_o,
  output logic nr_o,
  output logic tx_clk_o,
  output logic tx_slot_o,
  input wire logic tx_bit_i
);
  bit bit_fifo[$];
  logic [7:0] got[$];
  int frames = 0;
  int ones = 0;
  int flags = 0;
  logic slot_seen = 1'b0;
  logic [1:0] tcnt = 2'h0;

  // receive strobes idle; transmit clock runs free, phase unrelated to clk_i
  initial begin
    {rx_clk_o, rx_dat_o, ovh_o, stf_o, cj_o, slot_o, nr_o, tx_slot_o} = 8'h01;
    tx_clk_o = 1'b0;
    #37;
    forever #400 tx_clk_o = ~tx_clk_o;
  end

  // every fourth transmit bit belongs to other traffic
  always @(negedge tx_clk_o) begin
    tcnt = tcnt + 2'h1;
    tx_slot_o = (tcnt != 2'h3);
  end

  // one receive bit: clock pulses once, data line inverted once released
  task send_bit(input logic d, input logic o, input logic s, input logic c,
                input logic l, input logic n);
    {rx_dat_o, ovh_o, stf_o, cj_o, slot_o, nr_o} <= {d, o, s, c, l, n};
    #217 rx_clk_o <= 1'b1;
    #400 rx_clk_o <= 1'b0;
    #100 rx_dat_o <= ~d;
    #83;
  endtask : send_bit

  // flag search and zero deletion; a closed frame lands in got
  always @(posedge tx_clk_o) begin
    if (slot_seen) begin
      if (tx_bit_i === 1'b1) begin
        ones++;
        bit_fifo.push_back(1'b1);
      end else if (ones == 5) begin
        ones = 0;
      end else if (ones == 6) begin
        flags++;
        repeat (7) if (bit_fifo.size() > 0) void'(bit_fifo.pop_back());
        if (bit_fifo.size() >= 8 && bit_fifo.size() % 8 == 0) begin
          for (int i = 0; i < bit_fifo.size(); i += 8) begin
            got.push_back({bit_fifo[i+7], bit_fifo[i+6], bit_fifo[i+5], bit_fifo[i+4],
                           bit_fifo[i+3], bit_fifo[i+2], bit_fifo[i+1], bit_fifo[i]});
          end
          frames++;
        end
        bit_fifo.delete();
        ones = 0;
      end else begin
        ones = 0;
        bit_fifo.push_back(1'b0);
      end
    end
    slot_seen = tx_slot_o;
  end
endmodule : fdl_far_model
`default_nettype wire

// ==== sim/testbench.sv ====
/*
  self-checking bench of the data-link and gapped-clock core.
  assumes fdl_far_model stands on the line side and a classic wishbone
  master on the register side.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench
  import fdl_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq_n, gck, sout, tbit;
  logic rck, rdt, ovh, stf, cj, slot, nr, tck, tslot;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  int err_total = 0, checks = 0, seed = 31, ticks = 0, ones_seen = 0;
  logic [7:0] exp_q[$];
  logic [5:0] offs [5] = '{OFF_OVH, OFF_TXC, OFF_TXT, OFF_RXC, OFF_RXT};
  logic [7:0] rstv [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h7F};
  logic [7:0] msk [5] = '{8'h07, 8'h0F, 8'h7F, 8'h3F, 8'h7F};

  always #50 clk_i = ~clk_i;

  fdl_core #(.DEPTH(128)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rx_extract_clock_i(rck), .rx_line_data_i(rdt), .rx_ovh_pos_i(ovh),
    .rx_stuff_pos_i(stf), .rx_justif_pos_i(cj), .rx_link_slot_i(slot), .rx_nr_slot_i(nr),
    .tx_line_clock_i(tck), .tx_link_slot_i(tslot), .rx_gapped_clock_o(gck),
    .rx_serial_out_o(sout), .tx_link_bit_o(tbit), .irq_out_n_o(irq_n));

  fdl_far_model far_u (.rx_clk_o(rck), .rx_dat_o(rdt), .ovh_o(ovh), .stf_o(stf), .cj_o(cj),
    .slot_o(slot), .nr_o(nr), .tx_clk_o(tck), .tx_slot_o(tslot), .tx_bit_i(tbit));

  // ticks and ticked ones seen on the gapped clock
  always @(posedge gck) ticks++;
  always @(negedge gck) ones_seen += int'(sout === 1'b1);

  // ------------------------------------------------------------------
  // bus, compare and expectation helpers
  // ------------------------------------------------------------------
  task print_verdict;
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    checks++;
    if (got !== e) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, e);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d,
                    output logic [7:0] r);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, 24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat[7:0];
    {cyc, stb} <= 2'b00;
    if (n >= 50) err_total++;
  endtask : wb

  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] r;
    wb(1'b0, a, 8'h00, r);
    chk(r & m, e & m);
  endtask : rd

  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk_i);
    chk({7'h00, irq_n}, {7'h00, e});
  endtask : irq_is

  function automatic logic [15:0] fcs_of(input logic [7:0] m[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (m[i]) for (int j = 0; j < 8; j++) c = (c >> 1) ^ ((c[0] ^ m[i][j]) ? 16'h8408 : 16'h0000);
    return ~c;
  endfunction : fcs_of

  function automatic logic exp_tick(input logic [1:0] md, input logic [2:0] s, input int cls);
    if (s[OV_ALL] || cls == 0) return 1'b1;
    if (md == MODE_CBIT || md == MODE_G832) return 1'b0;
    return (cls == 2 && s[OV_STF]) || (cls == 3 && s[OV_CJ]);
  endfunction : exp_tick

  // one link bit followed by one payload bit outside the link slot
  task automatic lbit(input logic b, input logic on_nr);
    far_u.send_bit(b, 1'b1, 1'b0, 1'b0, ~on_nr, on_nr);
    far_u.send_bit(~b, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
  endtask : lbit

  task automatic rx_frame(input int len, input logic bad, input logic on_nr);
    logic [15:0] c;
    int ones;
    exp_q.delete();
    for (int k = 0; k < len; k++) exp_q.push_back(8'($random(seed)));
    c = fcs_of(exp_q) ^ {15'h0000, bad};
    exp_q.push_back(c[7:0]);
    exp_q.push_back(c[15:8]);
    for (int j = 0; j < 8; j++) lbit(HDLC_FLAG[j], on_nr);
    ones = 0;
    foreach (exp_q[i]) for (int j = 0; j < 8; j++) begin
      lbit(exp_q[i][j], on_nr);
      ones = exp_q[i][j] ? ones + 1 : 0;
      if (ones == 5) begin
        lbit(1'b0, on_nr);
        ones = 0;
      end
    end
    for (int j = 0; j < 8; j++) lbit(HDLC_FLAG[j], on_nr);
    repeat (10) @(posedge clk_i);
  endtask : rx_frame

  task automatic drain;
    foreach (exp_q[i]) rd(OFF_RXB, exp_q[i], 8'hFF);
  endtask : drain

  task automatic tx_msg(input int len, input logic fcs);
    logic [7:0] m[$], r;
    logic [15:0] c;
    int n;
    far_u.got.delete();
    far_u.frames = 0;
    for (int k = 0; k < len; k++) m.push_back(8'($random(seed)));
    for (int k = 0; k < len; k++) wb(1'b1, (k == len - 1) ? OFF_TXL : OFF_TXM, m[k], r);
    c = fcs_of(m);
    if (fcs) m = {m, c[7:0], c[15:8]};
    n = 0;
    while (far_u.frames == 0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    chk(8'(far_u.got.size()), 8'(m.size()));
    foreach (m[i]) chk(far_u.got[i], m[i]);
  endtask : tx_msg

  // ------------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin : watchdog
    #6000000;
    err_total++;
    print_verdict;
  end

  initial begin : main
    logic [7:0] r, d8;
    int cls, et, eo;
    logic d;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) rd(offs[i], rstv[i], 8'hFF);
    rd(6'h3C, 8'h00, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      d8 = 8'($random(seed)) & msk[i];
      wb(1'b1, offs[i], d8, r);
      rd(offs[i], d8, 8'hFF);
      wb(1'b1, offs[i], rstv[i], r);
    end
    for (int md = 0; md < 4; md++) begin
      wb(1'b1, OFF_MODE, 8'(md), r);
      for (int s = 0; s < 8; s++) begin
        wb(1'b1, OFF_OVH, 8'(s), r);
        {ticks, ones_seen, et, eo} = '0;
        repeat (12) begin
          cls = $unsigned($random(seed)) % 4;
          d = 1'($random(seed));
          far_u.send_bit(d, cls != 0, cls == 2, cls == 3, 1'b0, 1'b0);
          if (exp_tick(2'(md), 3'(s), cls)) begin
            et++;
            eo += int'(d);
          end
        end
        repeat (5) @(posedge clk_i);
        chk(8'(ticks), 8'(et));
        chk(8'(ones_seen), 8'(eo));
      end
    end
    wb(1'b1, OFF_MODE, 8'(MODE_CBIT), r);
    wb(1'b1, OFF_RXT, 8'h02, r);
    wb(1'b1, OFF_RXC, 8'h0F, r);
    rx_frame(3, 1'b0, 1'b0);
    rd(OFF_ST, 8'h30, 8'h70);
    irq_is(1'b0);
    drain;
    rd(OFF_ST, 8'h20, 8'h70);
    rd(OFF_ST, 8'h00, 8'h30);
    irq_is(1'b1);
    rx_frame(4, 1'b1, 1'b0);
    rd(OFF_ST, 8'h50, 8'h50);
    drain;
    wb(1'b1, OFF_RXC, 8'h09, r);
    rx_frame(2, 1'b1, 1'b0);
    rd(OFF_ST, 8'h10, 8'h50);
    drain;
    wb(1'b1, OFF_MODE, 8'(MODE_G832), r);
    wb(1'b1, OFF_RXC, 8'h2B, r);
    rx_frame(3, 1'b0, 1'b1);
    rd(OFF_ST, 8'h10, 8'h50);
    drain;
    wb(1'b1, OFF_RXC, 8'h0B, r);
    rx_frame(2, 1'b0, 1'b1);
    rd(OFF_ST, 8'h00, 8'h10);
    wb(1'b1, OFF_MODE, 8'(MODE_CBIT), r);
    wb(1'b1, OFF_RXC, 8'h11, r);
    rx_frame(130, 1'b0, 1'b0);
    irq_is(1'b0);
    rd(OFF_ST, 8'h08, 8'h48);
    for (int i = 0; i < 128; i++) rd(OFF_RXB, exp_q[i], 8'hFF);
    rd(OFF_ST, 8'h20, 8'h28);
    wb(1'b1, OFF_RXC, 8'h1E, r);
    rx_frame(3, 1'b0, 1'b0);
    rd(OFF_ST, 8'h00, 8'h78);
    irq_is(1'b1);
    wb(1'b1, OFF_TXC, 8'h09, r);
    tx_msg(3, 1'b1);
    irq_is(1'b0);
    rd(OFF_ST, 8'h01, 8'h01);
    irq_is(1'b1);
    wb(1'b1, OFF_TXC, 8'h00, r);
    tx_msg(2, 1'b0);
    wb(1'b1, OFF_TXC, 8'h04, r);
    d8 = 8'($random(seed));
    cls = far_u.flags;
    wait (far_u.flags != cls);
    wb(1'b1, OFF_TXM, d8, r);
    rd(OFF_TXL, d8, 8'hFF);
    repeat (600) @(posedge clk_i);
    irq_is(1'b0);
    rd(OFF_ST, 8'h02, 8'h02);
    wb(1'b1, OFF_TXC, 8'h02, r);
    irq_is(1'b0);
    rd(OFF_ST, 8'h04, 8'h04);
    wb(1'b1, OFF_TXC, 8'h00, r);
    rd(OFF_ST, 8'h04, 8'h07);
    irq_is(1'b1);
    print_verdict;
  end
endmodule : testbench
`default_nettype wire
